// ---- design/uart_addr_match_baud_select.sv ----
// Address recognition and baud source selection with AXI4-Lite regs
//
// What this block does
// - Mode 1 matching uses stop bit as ninth
// - Mode 1 flag only on match and good stop
// - Own address is given or broadcast match
// - Given address: zero mask bits are don't-care
// - Broadcast is address OR mask, zeros don't-care
// - Reset clears address and mask registers
// - Transmit and receive sources chosen independently
// - Select 0 timer overflow, 1 internal generator
// - Generator rate from reload, doubling, speed bits
// - Recognition only while multiprocessor enable set
// - Generator optionally clocks mode 0 shifting
`timescale 1ns/10ps
`include "uart_am_regs.svh"
module uart_addr_match_baud_select #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Frames from the receive shifter
  input wire uart_am_pkg::rx_frame_type frame,
  input wire logic frame_valid,
  output logic frame_ready,
  // Baud sources and selected ticks
  input wire logic timer1_overflow,
  output logic tx_baud_tick,
  output logic rx_baud_tick,
  output logic mode0_shift_tick,
  output logic rx_done_flag
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  uart_am_pkg::serial_mode_type mode_r;
  uart_am_pkg::baud_ctrl_type bctrl_r;
  logic multiproc_enable_r;
  logic rx_done_r;
  logic listening_r;
  logic [7:0] slave_address_reg_r;
  logic [7:0] address_mask_reg_r;
  logic [7:0] baud_reload_value_r;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_held_r & w_held_r & ~bvalid_r;
  wire wr_lane0 = wstrb_r[0];
  wire sel_w_ctrl = wr_fire & (waddr_r == `SERIAL_CTRL_OFS);
  wire sel_w_slave_address_reg = wr_fire & (waddr_r == `SLAVE_ADDR_OFS);
  wire sel_w_mask = wr_fire & (waddr_r == `ADDR_MASK_OFS);
  wire sel_w_reload = wr_fire & (waddr_r == `BAUD_RELOAD_OFS);
  wire sel_w_bctrl = wr_fire & (waddr_r == `BAUD_CTRL_OFS);
  wire wr_mapped = (waddr_r == `SERIAL_CTRL_OFS)
                 | (waddr_r == `SLAVE_ADDR_OFS)
                 | (waddr_r == `ADDR_MASK_OFS)
                 | (waddr_r == `BAUD_RELOAD_OFS)
                 | (waddr_r == `BAUD_CTRL_OFS);
  // Writing zero to the done bit clears it; writing one leaves it
  wire done_clear = sel_w_ctrl & wr_lane0 & ~wdata_r[`CTRL_DONE_BIT];

  // Address and data may arrive in either order; each is held
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      if (aw_take)
        waddr_r <= {s_axi_awaddr[7:2], 2'b00};
      if (w_take)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      aw_held_r <= (aw_held_r & ~wr_fire) | aw_take;
      w_held_r <= (w_held_r & ~wr_fire) | w_take;
      s_axi_awready <= ~aw_held_r & ~aw_take & ~s_axi_awready;
      s_axi_wready <= ~w_held_r & ~w_take & ~s_axi_wready;
    end
  end

  // Write response, unmapped offsets answer SLVERR
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `AXI_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? `AXI_OKAY : `AXI_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Address and mask both clear at reset: every bit is don't-care
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      slave_address_reg_r <= `SLAVE_ADDR_RST;
      address_mask_reg_r <= `ADDR_MASK_RST;
      baud_reload_value_r <= `BAUD_RELOAD_RST;
      mode_r <= uart_am_pkg::MODE_SHIFT;
      multiproc_enable_r <= 1'b0;
      bctrl_r <= '0;
    end
    else
    begin
      if (sel_w_slave_address_reg & wr_lane0)
        slave_address_reg_r <= wdata_r[7:0];
      if (sel_w_mask & wr_lane0)
        address_mask_reg_r <= wdata_r[7:0];
      if (sel_w_reload & wr_lane0)
        baud_reload_value_r <= wdata_r[7:0];
      if (sel_w_ctrl & wr_lane0)
      begin
        mode_r <= uart_am_pkg::serial_mode_type'(
          wdata_r[`CTRL_MODE_LSB +: 2]);
        multiproc_enable_r <= wdata_r[`CTRL_MPE_BIT];
      end
      if (sel_w_bctrl & wr_lane0)
        bctrl_r <= wdata_r[6:0];
    end
  end

  // ----------------------------------------------------------------
  // Address recognition
  // ----------------------------------------------------------------
  uart_am_pkg::rx_word_type fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic rd_pop;

  wire [7:0] bcast_addr = slave_address_reg_r | address_mask_reg_r;
  wire given_hit = ((frame.data ^ slave_address_reg_r)
                   & address_mask_reg_r) == 8'h00;
  wire bcast_hit = ((frame.data ^ bcast_addr) & bcast_addr) == 8'h00;
  wire addr_hit = given_hit | bcast_hit;
  wire is_nine_bit = (mode_r == uart_am_pkg::MODE_9BIT_FIXED)
                   | (mode_r == uart_am_pkg::MODE_9BIT_VAR);
  // Shift mode never filters, even if the enable bit is set by mistake
  wire recog_on = multiproc_enable_r
                & (mode_r != uart_am_pkg::MODE_SHIFT);
  wire frame_take = frame_valid & frame_ready;
  wire addr_frame = is_nine_bit & frame.ninth;
  // In 8-bit mode the stop bit stands where the ninth bit would be
  wire accept_8bit = addr_hit & frame.stop_ok;
  wire accept_9bit = addr_frame ? addr_hit : listening_r;
  wire accept = ~recog_on
              | (is_nine_bit ? accept_9bit : accept_8bit);
  wire push = frame_take & accept;
  // Ninth position stores the stop bit in 8-bit mode
  wire stored_ninth = is_nine_bit ? frame.ninth : frame.stop_ok;

  // Listening persists after a match until disable or a missed address
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      listening_r <= 1'b0;
    else if (~recog_on | ~is_nine_bit)
      listening_r <= 1'b0;
    else if (frame_take & addr_frame)
      listening_r <= addr_hit;
  end

  // Done flag: a new frame in the clearing cycle keeps it set
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      rx_done_r <= 1'b0;
    else if (push)
      rx_done_r <= 1'b1;
    else if (done_clear)
      rx_done_r <= 1'b0;
  end

  // Accepted frames queue here until software reads them
  rx_word_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({stored_ninth, frame.data}),
    .out_valid(fifo_out_valid),
    .out_ready(rd_pop),
    .out_data(fifo_out)
  );

  // Frames stall while the queue is full, rejected ones included
  assign frame_ready = fifo_in_ready;
  assign rx_done_flag = rx_done_r;

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic arready_r;
  logic [31:0] rd_mux;
  logic rd_ok;

  wire ar_take = s_axi_arvalid & arready_r;
  wire [7:0] raddr = {s_axi_araddr[7:2], 2'b00};
  // Reading the data word pops one entry from the queue
  assign rd_pop = ar_take & (raddr == `RX_DATA_OFS) & fifo_out_valid;

  // Read decode; unmapped offsets return zero with SLVERR
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (raddr)
      `SERIAL_CTRL_OFS:
        rd_mux[3:0] = {rx_done_r, multiproc_enable_r, mode_r};
      `SLAVE_ADDR_OFS: rd_mux[7:0] = slave_address_reg_r;
      `ADDR_MASK_OFS: rd_mux[7:0] = address_mask_reg_r;
      `BAUD_RELOAD_OFS: rd_mux[7:0] = baud_reload_value_r;
      `BAUD_CTRL_OFS: rd_mux[6:0] = bctrl_r;
      `STATUS_OFS:
        rd_mux[2:0] = {~fifo_in_ready, listening_r, fifo_out_valid};
      `RX_DATA_OFS:
        rd_mux[`RXD_VALID_BIT:0] = {fifo_out_valid, fifo_out};
      default: rd_ok = 1'b0;
    endcase
  end

  // One read outstanding; arready drops while the answer waits
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `AXI_OKAY;
    end
    else if (ar_take)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
    end
    else if (rvalid_r)
    begin
      rvalid_r <= ~s_axi_rready;
      arready_r <= 1'b0;
    end
    else
      arready_r <= 1'b1;
  end

  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ----------------------------------------------------------------
  // Internal baud generator
  // ----------------------------------------------------------------
  logic [4:0] presc_r;
  logic [7:0] gen_cnt_r;
  logic gen_ovf_r;
  logic [3:0] m0_div_r;

  // Prescale: six without speed mode, doubled per clear doubling bit
  wire [4:0] presc_base = bctrl_r.speed_mode_bit ? 5'h01
                                                : `LOW_SPEED_DIV;
  wire [1:0] presc_shift = 2'(~bctrl_r.clock_double_bit)
                         + 2'(~bctrl_r.baud_double_bit);
  wire [4:0] presc_limit = presc_base << presc_shift;
  wire presc_wrap = (presc_r >= presc_limit - 5'h01);
  wire gen_step = bctrl_r.gen_run & presc_wrap;
  wire gen_wrap = gen_step & (gen_cnt_r == 8'hFF);

  // Counter runs up from the reload value; overflow is the tick
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      presc_r <= 5'h00;
      gen_cnt_r <= 8'h00;
      gen_ovf_r <= 1'b0;
    end
    else
    begin
      presc_r <= (presc_wrap | ~bctrl_r.gen_run) ? 5'h00
                                                 : presc_r + 5'h01;
      if (~bctrl_r.gen_run | gen_wrap)
        gen_cnt_r <= baud_reload_value_r;
      else if (gen_step)
        gen_cnt_r <= gen_cnt_r + 8'h01;
      gen_ovf_r <= gen_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Tick selection
  // ----------------------------------------------------------------
  wire m0_div_wrap = (m0_div_r == `MODE0_DIV - 4'h1);
  wire m0_src = bctrl_r.mode0_clock_from_gen ? gen_ovf_r
                                             : m0_div_wrap;
  wire tx_src = bctrl_r.tx_baud_source_sel ? gen_ovf_r
                                           : timer1_overflow;
  wire rx_src = bctrl_r.rx_baud_source_sel ? gen_ovf_r
                                           : timer1_overflow;

  // Every tick output is registered, one cycle after its source
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      m0_div_r <= 4'h0;
      tx_baud_tick <= 1'b0;
      rx_baud_tick <= 1'b0;
      mode0_shift_tick <= 1'b0;
    end
    else
    begin
      m0_div_r <= m0_div_wrap ? 4'h0 : m0_div_r + 4'h1;
      tx_baud_tick <= tx_src;
      rx_baud_tick <= rx_src;
      mode0_shift_tick <= m0_src & (mode_r == uart_am_pkg::MODE_SHIFT);
    end
  end

endmodule : uart_addr_match_baud_select

// ---- include/uart_am_regs.svh ----
// Register offsets, field positions, reset values and counts
`ifndef UART_AM_REGS_SVH
`define UART_AM_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SERIAL_CTRL_OFS 8'h00
`define SLAVE_ADDR_OFS 8'h04
`define ADDR_MASK_OFS 8'h08
`define BAUD_RELOAD_OFS 8'h0C
`define BAUD_CTRL_OFS 8'h10
`define STATUS_OFS 8'h14
`define RX_DATA_OFS 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_MPE_BIT 2
`define CTRL_DONE_BIT 3
`define BCTRL_TXSEL_BIT 0
`define BCTRL_RXSEL_BIT 1
`define BCTRL_SPD_BIT 2
`define BCTRL_SRC_BIT 3
`define BCTRL_RUN_BIT 4
`define BCTRL_X2_BIT 5
`define BCTRL_DBL_BIT 6
`define STAT_AVAIL_BIT 0
`define STAT_LISTEN_BIT 1
`define STAT_FULL_BIT 2
`define RXD_VALID_BIT 9

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SLAVE_ADDR_RST 8'h00
`define ADDR_MASK_RST 8'h00
`define BAUD_RELOAD_RST 8'h00
`define LOW_SPEED_DIV 5'h06
`define MODE0_DIV 4'hC
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// ---- include/uart_am_pkg.sv ----
// Types shared by the address-match and baud-select block
package uart_am_pkg;

  // Serial port operating modes
  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_8BIT,
    MODE_9BIT_FIXED,
    MODE_9BIT_VAR
  } serial_mode_type;

  // One received frame as delivered by the receiver shifter
  typedef struct packed {
    logic stop_ok;
    logic ninth;
    logic [7:0] data;
  } rx_frame_type;

  // One word held in the receive FIFO
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } rx_word_type;

  // Baud generator control bits
  typedef struct packed {
    logic baud_double_bit;
    logic clock_double_bit;
    logic gen_run;
    logic mode0_clock_from_gen;
    logic speed_mode_bit;
    logic rx_baud_source_sel;
    logic tx_baud_source_sel;
  } baud_ctrl_type;

endpackage : uart_am_pkg

// ---- design/rx_word_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module rx_word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic full_r;
  wire push = in_valid & ~full_r;
  wire pop = out_ready & (count_r != '0);

  // Full is registered so the filling side sees a clean ready
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = ~full_r;
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];

  // Storage; no reset needed on the data array
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  // Pointers and occupancy
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      full_r <= 1'b0;
    end
    else
    begin
      wr_ptr_r <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_r <= pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
      count_r <= count_nxt;
      full_r <= (count_nxt == (AW+1)'(DEPTH));
    end
  end

endmodule : rx_word_fifo

// ---- tb/uart_am_props.sv ----
// Port-level checker for the address match and baud select block
`timescale 1ns/10ps
`include "uart_am_regs.svh"
module uart_am_props (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_baud_tick,
  input wire logic rx_done_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Takes of the two write channels
  sequence aw_take;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence w_take;
    s_axi_wvalid && s_axi_wready;
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  // Answers stand until the master takes them
  bwait_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
  rwait_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  pair_answer_a: assert property ((aw_take and w_take) |-> ##2
    s_axi_bvalid) else $error("write answer late");
  write_cause_a: assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_awvalid && s_axi_awready, 2) ||
    $past(s_axi_wvalid && s_axi_wready, 2)) else $error("stray answer");
  // The write address ready is a single-cycle pulse
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  resp_code_a: assert property (s_axi_bvalid |->
    s_axi_bresp == `AXI_OKAY || s_axi_bresp == `AXI_SLVERR)
    else $error("bad write response");
  err_data_a: assert property (s_axi_rvalid &&
    s_axi_rresp == `AXI_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  // The done flag only drops through a register write
  done_clear_a: assert property ($fell(rx_done_flag) |-> s_axi_bvalid)
    else $error("done flag dropped alone");
  // A source switch may join two ticks; the write answer marks it
  tick_pulse_a: assert property (
    tx_baud_tick && !s_axi_bvalid |=> !tx_baud_tick)
    else $error("tick too long");
endmodule : uart_am_props
bind uart_addr_match_baud_select uart_am_props props_i (
  .core_clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .tx_baud_tick, .rx_done_flag
);

// ---- tb/serial_peer.sv ----
// Peer node model that hands received frames to the block
`timescale 1ns/10ps
module serial_peer (
  input wire logic core_clk,
  input wire logic frame_ready,
  output uart_am_pkg::rx_frame_type frame,
  output logic frame_valid
);
  uart_am_pkg::rx_frame_type q[$];
  int gap = 0;
  // ------------------------------------------------------------
  // Offer loop
  // ------------------------------------------------------------
  // Holds each frame until taken; idle lines show the inverse so
  // a stale frame can never pass for a fresh one
  initial
  begin
    frame = 10'h155;
    frame_valid = 1'b0;
    forever
    begin
      @(posedge core_clk);
      gap = (gap + 1) % 3;
      if (frame_valid && frame_ready)
      begin
        void'(q.pop_front());
        frame_valid <= 1'b0;
        frame <= ~frame;
      end
      else if (!frame_valid && q.size() > 0 && gap == 0)
      begin
        frame <= q[0];
        frame_valid <= 1'b1;
      end
    end
  end
endmodule : serial_peer

// ---- tb/test_uart_addr_match_baud_select.sv ----
// Self-checking bench for address match and baud source selection
`timescale 1ns/10ps
`include "uart_am_regs.svh"
module test_uart_addr_match_baud_select;
  logic core_clk = 1'b0, rst_b = 1'b0, timer1_overflow = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb = 4'hF, ctl = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic frame_valid, frame_ready, tx_baud_tick, rx_baud_tick;
  logic mode0_shift_tick, rx_done_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  uart_am_pkg::rx_frame_type frame, f, dq[$];
  logic [33:0] exp_q[$], got, want;
  logic [31:0] seed = 32'h0000000C;
  logic [19:0] e;
  int errors = 0, total_checks = 0, ph = 0, txc = 0, rxc = 0, mc = 0;
  int s[3];
  // Control, stop and ninth, data, accept and listening per frame
  logic [19:0] tbl[16] = '{20'h635A3, 20'h62003, 20'h73F30, 20'h72000,
    20'h73F03, 20'h72003, 20'h73FB3, 20'h73FF3, 20'h73000, 20'h52F02,
    20'h50F00, 20'h52FB2, 20'h52000, 20'h33002, 20'h32002, 20'h03A52};
  // Baud control, then tick counts of tx, rx and mode 0 per window
  logic [31:0] bt[7] = '{32'h14C0C050, 32'h153CC050, 32'h16C03C50,
    32'h57787850, 32'h1F3C3C3C, 32'h77F0F050, 32'h130A0A50};
  uart_addr_match_baud_select #(.FIFO_DEPTH(16)) DUT (
    .core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .frame, .frame_valid, .frame_ready,
    .timer1_overflow, .tx_baud_tick, .rx_baud_tick, .mode0_shift_tick,
    .rx_done_flag);
  serial_peer src (.core_clk, .frame_ready, .frame, .frame_valid);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  always #2 core_clk = ~core_clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Phase of a few cycles allowed between window and tick train
  function automatic int near(int g, int x);
    return (g >= x - 1 && g <= x + 1) ? x : g;
  endfunction : near
  task automatic chk(string n, logic [33:0] x, logic [33:0] g);
    total_checks++;
    if (g !== x)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, x, g);
    end
  endtask : chk
  task automatic cchk(string n, int g, logic [7:0] x);
    chk(n, 34'(x), 34'(near(g, x)));
  endtask : cchk
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] p = 2'h0);
    bit aw, w;
    exp_q.push_back({p, 32'h0});
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w)
    begin
      @(posedge core_clk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] d, logic [1:0] p = 2'h0);
    exp_q.push_back({p, d});
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // Timer overflow every fifth cycle, and tick counting
  always @(posedge core_clk)
  begin
    ph <= (ph == 4) ? 0 : ph + 1;
    timer1_overflow <= (ph == 4);
    txc <= txc + tx_baud_tick;
    rxc <= rxc + rx_baud_tick;
    mc <= mc + mode0_shift_tick;
  end
  // Each bus answer is held against the oldest note
  always @(posedge core_clk)
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
    begin
      got = s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
      want = exp_q.pop_front();
      chk("bus answer", want, got);
    end
  // Watchdog well beyond the expected run
  initial
  begin
    #200000;
    errors++;
    report_and_stop();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(`SLAVE_ADDR_OFS, 32'h0);
    rd(`ADDR_MASK_OFS, 32'h0);
    rd(8'h1C, 32'h0, 2'h2);
    wr(8'h1C, 32'h0, 2'h2);
    wr(`BAUD_RELOAD_OFS, 32'hFC);
    $display("reset test done");
    foreach (tbl[i])
    begin
      e = tbl[i];
      if (i == 2)
      begin
        wr(`SLAVE_ADDR_OFS, 32'hF1);
        wr(`ADDR_MASK_OFS, 32'hFA);
      end
      if (e[19:16] != ctl)
      begin
        ctl = e[19:16];
        wr(`SERIAL_CTRL_OFS, {28'h0, ctl});
      end
      r = rnd();
      f = {e[13:12], e[11:4]};
      if (ctl[1] && !e[12])
        f.data = r[7:0];
      src.q.push_back(f);
      for (int k = 0; k < 200 && src.q.size() != 0; k++)
        @(posedge core_clk);
      repeat (3) @(posedge core_clk);
      if (e[1])
        rd(`RX_DATA_OFS, {23'h1, ctl[1:0] == 2'h1 ? f.stop_ok : f.ninth,
          f.data});
      rd(`STATUS_OFS, {30'h0, e[0], 1'b0});
    end
    chk("done flag", 34'h1, {33'h0, rx_done_flag});
    wr(`SERIAL_CTRL_OFS, 32'h0);
    chk("done flag", 34'h0, {33'h0, rx_done_flag});
    $display("address test done");
    for (int k = 0; k < 17; k++)
    begin
      r = rnd();
      dq.push_back({2'h3, r[7:0]});
      src.q.push_back(dq[k]);
    end
    repeat (150) @(posedge core_clk);
    chk("frame ready", 34'h0, {33'h0, frame_ready});
    rd(`STATUS_OFS, 32'h5);
    foreach (dq[k])
      rd(`RX_DATA_OFS, {23'h1, dq[k].ninth, dq[k].data});
    rd(`STATUS_OFS, 32'h0);
    $display("fifo test done");
    foreach (bt[i])
    begin
      wr(`BAUD_CTRL_OFS, {24'h0, bt[i][31:24]});
      repeat (200) @(posedge core_clk);
      s = '{txc, rxc, mc};
      repeat (960) @(posedge core_clk);
      cchk("tx ticks", txc - s[0], bt[i][23:16]);
      cchk("rx ticks", rxc - s[1], bt[i][15:8]);
      cchk("shift ticks", mc - s[2], bt[i][7:0]);
    end
    $display("baud test done");
    report_and_stop();
  end
endmodule : test_uart_addr_match_baud_select
